// file: hw/lrp_port.sv
// Purpose: serial target front end with locality-gated register set
// Assumes: scl and sda sampled on i_ref_clk (250 MHz), link far slower
// Notes:   command engine, arbitration and checksum math stay outside
`timescale 1ns/1ps
`default_nettype none
`include "lrp_cfg.svh"

// Function
// - low-active interrupt pin flags response ready
// - status/data gated by active locality, else 0xFF
// - hash-start claims locality four when idle
// - hash-end releases locality four while locality select is four
// - common registers reachable regardless of locality
// - nack wrong address or when busy
// - nack write byte that cannot be taken
// - nacked transfer discards its received bytes
// - first write byte selects sub-address
// - multi-byte values go least byte first
// - invalid or past-end reads return 0xFF, except status begun at 0x19 or 0x1B, which wraps to byte 0
// - overrun write of up to four bytes still updates start register
// - full-length write at base is applied
// - base read returns low bytes first
// - single-byte status writes at 0x18, 0x1B
// - middle status byte 0x19 ignores writes
// - two-byte read at 0x19 gives status bits
// - single read at 0x1B gives top status
// - locality select resets zero, holds writes
// - locality select frozen during measurement
// - stretch clock when data not ready
module lrp_port
  import lrp_pkg::*;
(
  input  wire logic        i_ref_clk,      // 250 MHz device clock
  input  wire logic        i_srst,         // sync reset, high
  input  wire logic        i_scl,          // link clock pin
  input  wire logic        i_sda,          // link data pin
  output logic             o_scl_oe,       // hold scl low (stretch)
  output logic             o_sda_oe,       // pull sda low
  output logic             o_sda_o,        // sda drive value, always 0
  output logic             o_host_irq_n,   // interrupt pin, low active
  input  wire logic        i_busy,         // core cannot serve a cycle
  input  wire logic [31:0] i_sts,          // module status from core
  input  wire logic [31:0] i_irq_flags,    // interrupt flags from core
  input  wire logic        i_resp_valid,   // core has a buffer byte
  input  wire logic [7:0]  i_resp_data,    // buffer byte from core
  output logic             o_resp_pop,     // tied low, core pops bytes on its own
  output logic             o_wr_stb,       // committed write pulse
  output logic [7:0]       o_wr_addr,      // its sub-address
  output logic [7:0]       o_wr_data,      // its byte
  output logic             o_hash_start,   // measurement began
  output logic             o_hash_end,     // measurement ended
  output logic [7:0]       o_locality_sel, // current locality
  output logic [31:0]      o_int_enable,   // interrupt enable register
  output logic             o_loc4_active   // locality four owns module
);
  localparam int WQ = 4; // pending bytes held for commit

  typedef struct packed {
    lrp_state_t  st;
    logic        scl_p, sda_p;
    logic [3:0]  bit_n;
    logic [7:0]  sh;
    logic        rd;
    logic        first;
    logic [7:0]  sub;
    logic [7:0]  base;
    logic [2:0]  wn;
    logic [WQ-1:0][7:0] wq;
    logic        nacked;
    logic        ack_out;
    logic        sda_oe, scl_oe;
    logic [7:0]  loc_sel;
    logic [31:0] int_en;
    logic        loc4;
    logic [7:0]  acc_req;
    logic [6:0]  dev_addr;
    logic        csum_en;
    logic        irq_n;
    logic        wr_stb;
    logic [7:0]  wr_addr, wr_data;
    logic        hs, he;
  } lrp_st_t;
  lrp_st_t q, d;

  logic scl_s, sda_s;
  logic tx_valid, tx_ready;
  logic [7:0] tx_byte;
  logic buf_push, buf_rdy, buf_flush;
  logic [7:0] buf_din;

  // ---------------------------------------------------------------
  // pin sampling
  // ---------------------------------------------------------------
  lrp_sync u_sync_scl (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_pin(i_scl), .o_sync(scl_s)
  );
  lrp_sync u_sync_sda (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_pin(i_sda), .o_sync(sda_s)
  );

  // read bytes pass a two-entry buffer so a late core stall loses nothing
  lrp_buf2 #(.W(8)) u_buf (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_flush(buf_flush),
    .i_valid(buf_push), .o_ready(buf_rdy), .i_data(buf_din),
    .o_valid(tx_valid), .i_ready(tx_ready), .o_data(tx_byte)
  );

  // ---------------------------------------------------------------
  // read value of one sub-address
  // ---------------------------------------------------------------
  function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [7:0] b,
                                         input logic own, input logic [31:0] s,
                                         input lrp_st_t r, input logic [31:0] f,
                                         input logic [7:0] acc);
    logic [31:0] w;
    logic [1:0]  k;
    logic        ok;
    k  = 2'(a - b);
    ok = 1'b1;
    w  = 32'h0;
    case (b)
      `LRP_A_LOC_SEL:   begin w = {24'h0, r.loc_sel}; ok = (a == b); end
      `LRP_A_ACCESS:    begin w = {24'h0, acc}; ok = (a == b); end
      `LRP_A_INT_EN:    w = r.int_en;
      `LRP_A_INT_FLAGS: w = f;
      `LRP_A_INT_SUP:   w = `LRP_INT_SUP_VAL;
      `LRP_A_STS, `LRP_A_STS1, `LRP_A_STS3: begin
        k  = a[1:0]; // status alone may start mid-word
        w  = s;
        ok = own;
      end
      `LRP_A_LINK_CAP:  w = `LRP_LINK_CAP_VAL;
      `LRP_A_BUS_ADDR:  begin w = {25'h0, r.dev_addr}; ok = (k < 2'h2); end
      `LRP_A_CSUM_EN:   begin w = {31'h0, r.csum_en}; ok = (a == b); end
      `LRP_A_CSUM:      begin w = 32'h0; ok = (k < 2'h2); end
      `LRP_A_IDENT:     w = `LRP_IDENT_VAL; // arbitrary identity value
      `LRP_A_REV:       begin w = {24'h0, `LRP_REV_VAL}; ok = (a == b); end
      default:          ok = 1'b0; // invalid, hash commands, past end
    endcase
    if ((a - b) > 8'h3) ok = 1'b0;
    rd_byte = ok ? w[8*k +: 8] : `LRP_FILL; // least byte first
  endfunction

  // ---------------------------------------------------------------
  // link state machine and register file
  // ---------------------------------------------------------------
  always_comb begin
    logic rise, fall, start, stop, own, adv;
    logic [7:0] acc, cur;
    d = q;
    d.scl_p = scl_s;
    d.sda_p = sda_s;
    d.wr_stb = 1'b0;
    d.hs = 1'b0;
    d.he = 1'b0;
    rise  = scl_s && !q.scl_p;
    fall  = !scl_s && q.scl_p;
    start = scl_s && q.scl_p && q.sda_p && !sda_s;
    stop  = scl_s && q.scl_p && !q.sda_p && sda_s;
    own   = q.loc4 ? (q.loc_sel == `LRP_LOC4) : 1'b0;
    acc   = 8'h0;
    acc[`LRP_ACC_VALID_BIT]  = 1'b1;
    acc[`LRP_ACC_ACTIVE_BIT] = own;
    acc[`LRP_ACC_REQ_BIT]    = q.acc_req[0];
    adv = (q.base != `LRP_A_DATA);
    buf_push  = 1'b0;
    buf_flush = 1'b0;
    tx_ready  = 1'b0;
    cur = rd_byte(q.sub, q.base, own, i_sts, q, i_irq_flags, acc);
    buf_din = cur;
    // the data buffer byte comes from the core, all others from the map
    // a byte is fetched when one is due and the buffer is empty, so the
    // first byte of a read never waits on an earlier prefetch
    if (q.base == `LRP_A_DATA) begin
      buf_din  = own ? i_resp_data : `LRP_FILL;
      buf_push = q.rd && q.st == LRP_TX && q.bit_n == 4'h0 && !tx_valid && buf_rdy
                 && (i_resp_valid || !own);
    end else begin
      buf_push = q.rd && q.st == LRP_TX && q.bit_n == 4'h0 && !tx_valid && buf_rdy;
    end
    // commit queued write bytes at stop unless the transfer was refused
    if (stop && !q.rd && !q.nacked && q.wn != 3'h0) begin
      d.wr_stb  = 1'b1;
      d.wr_addr = q.base;
      d.wr_data = q.wq[0];
      case (q.base)
        `LRP_A_LOC_SEL: if (!q.loc4) d.loc_sel = q.wq[0];
        `LRP_A_ACCESS:  d.acc_req = q.wq[0];
        `LRP_A_INT_EN: if (q.wn >= 3'h4)
          d.int_en = {q.wq[3], q.wq[2], q.wq[1], q.wq[0]} & `LRP_INT_EN_MASK;
        `LRP_A_HASH_START: if (!q.loc4) begin
          d.loc4 = 1'b1;
          d.hs   = 1'b1;
        end
        `LRP_A_HASH_END: if (q.loc4 && q.loc_sel == `LRP_LOC4) begin
          d.loc4 = 1'b0;
          d.he   = 1'b1;
        end
        `LRP_A_BUS_ADDR: if (q.wn >= 3'h2) d.dev_addr = q.wq[0][6:0];
        `LRP_A_CSUM_EN: d.csum_en = q.wq[0][0];
        `LRP_A_STS, `LRP_A_STS3: if (!own) d.wr_stb = 1'b0;
        `LRP_A_STS1: d.wr_stb = 1'b0;
        default: ;
      endcase
    end
    case (q.st)
      LRP_IDLE: ;
      LRP_ADDR, LRP_RX: if (rise) begin
        d.sh    = {q.sh[6:0], sda_s};
        d.bit_n = q.bit_n + 4'h1;
      end else if (fall && q.bit_n == 4'h8) begin
        d.st = LRP_ACK;
        d.ack_out = 1'b1;
        if (q.st == LRP_ADDR) begin
          d.rd = q.sh[0];
          if (q.sh[7:1] != q.dev_addr || i_busy) d.ack_out = 1'b0;
          if (q.sh[7:1] == q.dev_addr && i_busy) d.nacked = 1'b1;
        end else if (q.first) begin
          d.sub   = q.sh;
          d.base  = q.sh;
          d.first = 1'b0;
        end else if (q.wn == 3'(WQ)) begin
          d.ack_out = 1'b0; // no room left in this transfer
          d.nacked  = 1'b1;
        end else begin
          d.wq[q.wn[1:0]] = q.sh;
          d.wn = q.wn + 3'h1;
          if (adv) d.sub = q.sub + 8'h1;
        end
        d.sda_oe = d.ack_out;
      end
      LRP_ACK: if (fall) begin
        d.sda_oe = 1'b0;
        d.bit_n  = 4'h0;
        if (!q.ack_out) d.st = LRP_SKIP;
        else if (q.rd) d.st = LRP_TX;
        else d.st = LRP_RX;
      end
      LRP_TX: begin
        // hold scl low until the byte is ready
        d.scl_oe = !tx_valid && !scl_s;
        if (tx_valid && q.bit_n == 4'h0 && !scl_s) d.sda_oe = !tx_byte[7];
        if (tx_valid && fall) begin
          d.bit_n = q.bit_n + 4'h1;
          if (q.bit_n == 4'h7) begin
            d.st = LRP_TXACK;
            d.sda_oe = 1'b0;
            tx_ready = 1'b1;
            if (adv) d.sub = q.sub + 8'h1;
          end else d.sda_oe = !tx_byte[3'h6 - q.bit_n[2:0]];
        end
      end
      LRP_TXACK: if (rise) begin
        d.ack_out = !sda_s;
      end else if (fall) begin
        d.bit_n = 4'h0;
        d.st = q.ack_out ? LRP_TX : LRP_SKIP;
        if (!q.ack_out) buf_flush = 1'b1;
      end
      default: begin
        d.sda_oe = 1'b0;
        d.scl_oe = 1'b0;
      end
    endcase
    if (start) begin
      d.st = LRP_ADDR;
      d.bit_n = 4'h0;
      d.first = 1'b1;
      d.wn = 3'h0;
      d.nacked = 1'b0;
      d.sda_oe = 1'b0;
      d.scl_oe = 1'b0;
      d.ack_out = 1'b0;
      buf_flush = 1'b1;
    end
    if (stop) begin
      d.st = LRP_IDLE;
      d.sda_oe = 1'b0;
      d.scl_oe = 1'b0;
    end
    d.irq_n = !(i_irq_flags[0] && q.int_en[0] && q.int_en[31]) &&
              !(|(i_irq_flags[7:1] & q.int_en[7:1]) && q.int_en[31]);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      q <= '0;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
      q.st <= LRP_IDLE;
      q.loc_sel <= `LRP_LOC_RST;
      q.dev_addr <= `LRP_DEV_ADDR_RST;
      q.irq_n <= 1'b1;
    end else q <= d;
  end

  // ---------------------------------------------------------------
  // outputs from flip-flops, o_sda_o and o_resp_pop tied low
  // ---------------------------------------------------------------
  assign o_scl_oe = q.scl_oe;
  assign o_sda_oe = q.sda_oe;
  assign o_sda_o = 1'b0;
  assign o_host_irq_n = q.irq_n;
  assign o_resp_pop = 1'b0; // buffer bytes are taken by the core on its own pop
  assign o_wr_stb = q.wr_stb;
  assign o_wr_addr = q.wr_addr;
  assign o_wr_data = q.wr_data;
  assign o_hash_start = q.hs;
  assign o_hash_end = q.he;
  assign o_locality_sel = q.loc_sel;
  assign o_int_enable = q.int_en;
  assign o_loc4_active = q.loc4;
endmodule
`default_nettype wire

// file: include/lrp_cfg.svh
// Purpose: constants of the locality register port
// Assumes: byte sub-addresses on a two-wire serial link
// Notes:   definitions only
`ifndef LRP_CFG_SVH
`define LRP_CFG_SVH
`define LRP_DEV_ADDR_RST   7'h2E
`define LRP_A_LOC_SEL      8'h00
`define LRP_A_ACCESS       8'h04
`define LRP_A_INT_EN       8'h08
`define LRP_A_INT_FLAGS    8'h10
`define LRP_A_INT_SUP      8'h14
`define LRP_A_STS          8'h18
`define LRP_A_STS1         8'h19
`define LRP_A_STS3         8'h1B
`define LRP_A_HASH_END     8'h20
`define LRP_A_DATA         8'h24
`define LRP_A_HASH_START   8'h28
`define LRP_A_LINK_CAP     8'h30
`define LRP_A_BUS_ADDR     8'h38
`define LRP_A_CSUM_EN      8'h40
`define LRP_A_CSUM         8'h44
`define LRP_A_IDENT        8'h48
`define LRP_A_REV          8'h4C
`define LRP_FILL           8'hFF
`define LRP_LOC_RST        8'h00
`define LRP_LOC4           8'h04
`define LRP_INT_EN_MASK    32'h8000_0087
`define LRP_INT_SUP_VAL    32'h0000_0087
`define LRP_LINK_CAP_VAL   32'h0000_0000
`define LRP_IDENT_VAL      32'h0000_0000
`define LRP_REV_VAL        8'h00
`define LRP_ACC_ACTIVE_BIT 5
`define LRP_ACC_REQ_BIT    1
`define LRP_ACC_VALID_BIT  7
`endif

// file: include/lrp_pkg.sv
// Purpose: types of the locality register port
// Assumes: lrp_cfg.svh holds all numbers
// Notes:   none
package lrp_pkg;
  typedef enum logic [2:0] {
    LRP_IDLE, LRP_ADDR, LRP_ACK, LRP_RX, LRP_TX, LRP_TXACK, LRP_SKIP
  } lrp_state_t;
endpackage

// file: hw/lrp_sync.sv
// Purpose: two-flop synchroniser for one pin
// Assumes: input from another domain
// Notes:   first flop read only by the second
`timescale 1ns/1ps
`default_nettype none
module lrp_sync (
  input  wire logic i_ref_clk, // device clock
  input  wire logic i_srst,    // sync reset
  input  wire logic i_pin,     // raw pin
  output logic      o_sync     // synchronised level
);
  typedef struct packed { logic m; logic s; } lrp_sync_st_t;
  lrp_sync_st_t q, d;
  // shift through two stages; idle level is high on the bus
  always_comb begin
    d   = q;
    d.m = i_pin;
    d.s = q.m;
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) q <= '1;
    else q <= d;
  end
  assign o_sync = q.s;
endmodule
`default_nettype wire

// file: hw/lrp_buf2.sv
// Purpose: two-entry valid/ready buffer for read bytes
// Assumes: same clock on both sides
// Notes:   full and empty are exact
`timescale 1ns/1ps
`default_nettype none
module lrp_buf2 #(
  parameter int W = 8 // word width
) (
  input  wire logic         i_ref_clk, // device clock
  input  wire logic         i_srst,    // sync reset
  input  wire logic         i_flush,   // drop all words
  input  wire logic         i_valid,   // write side valid
  output logic              o_ready,   // write side ready
  input  wire logic [W-1:0] i_data,    // write data
  output logic              o_valid,   // read side valid
  input  wire logic         i_ready,   // read side ready
  output logic [W-1:0]      o_data     // read data
);
  typedef struct packed {
    logic [1:0][W-1:0] mem; logic [1:0] cnt;
  } lrp_buf_st_t;
  lrp_buf_st_t q, d;
  initial if (W < 1) $error("lrp_buf2: width must be positive");
  assign o_ready = (q.cnt != 2'h2);
  assign o_valid = (q.cnt != 2'h0);
  assign o_data  = q.mem[0];
  // entry 0 is always the head, so a pop shifts entry 1 down
  always_comb begin
    logic push;
    logic pop;
    push = i_valid && o_ready;
    pop  = o_valid && i_ready;
    d = q;
    if (pop) begin
      d.mem[0] = q.mem[1];
      d.cnt    = q.cnt - 2'h1;
    end
    if (push) d.mem[d.cnt[0]] = i_data;
    if (push) d.cnt = d.cnt + 2'h1;
    if (i_flush) d.cnt = 2'h0;
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) q <= '0;
    else q <= d;
  end
endmodule
`default_nettype wire

// file: bench/lrp_checker.sv
// Purpose: concurrent checks on the register port pins
// Assumes: one clock domain, synchronous high reset
// Notes:   bound onto every lrp_port instance
`timescale 1ns/1ps
`default_nettype none
`include "lrp_cfg.svh"
module lrp_checker (
  input wire logic        i_ref_clk,      // device clock
  input wire logic        i_srst,         // sync reset
  input wire logic        i_scl,          // clock wire
  input wire logic        i_sda,          // data wire
  input wire logic        o_scl_oe,       // stretch enable
  input wire logic        o_sda_oe,       // data pull enable
  input wire logic        o_sda_o,        // data drive value
  input wire logic        o_host_irq_n,   // interrupt pin
  input wire logic [31:0] i_irq_flags,    // core flags
  input wire logic        o_wr_stb,       // commit pulse
  input wire logic        o_hash_start,   // measurement begin
  input wire logic        o_hash_end,     // measurement end
  input wire logic [7:0]  o_locality_sel, // locality
  input wire logic [31:0] o_int_enable,   // enable register
  input wire logic        o_loc4_active   // locality four owns
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  // ----------------------------------------
  // pin and register relations
  // ----------------------------------------
  property p_irq_off; !o_int_enable[31] && !$past(o_int_enable[31]) |-> o_host_irq_n; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq low while disabled");
  property p_irq_on;
    (o_int_enable[31] && |(o_int_enable[7:0] & i_irq_flags[7:0])) [*3] |=> !o_host_irq_n;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq not raised");
  property p_en_mask; (o_int_enable & ~`LRP_INT_EN_MASK) == 32'h0; endproperty
  a_en_mask: assert property (p_en_mask) else $error("reserved enable bit set");
  property p_start_own; o_hash_start |=> o_loc4_active; endproperty
  a_start_own: assert property (p_start_own) else $error("start did not claim");
  property p_end_free; o_hash_end |=> !o_loc4_active; endproperty
  a_end_free: assert property (p_end_free) else $error("end did not release");
  property p_loc_freeze; $past(o_loc4_active) && o_loc4_active |-> $stable(o_locality_sel); endproperty
  a_loc_freeze: assert property (p_loc_freeze) else $error("locality changed");
  // commits happen only once the bus is back in stop state
  property p_commit_stop; o_wr_stb |-> i_scl && i_sda; endproperty
  a_commit_stop: assert property (p_commit_stop) else $error("commit outside stop");
  property p_sda_lowclk; $changed(o_sda_oe) |-> !i_scl; endproperty
  a_sda_lowclk: assert property (p_sda_lowclk) else $error("data moved, clock high");
  property p_sda_zero; o_sda_o == 1'b0; endproperty
  a_sda_zero: assert property (p_sda_zero) else $error("data drive not zero");
  property p_stretch; o_scl_oe |-> !i_scl; endproperty
  a_stretch: assert property (p_stretch) else $error("stretch not seen");
  property p_reset;
    disable iff (1'b0) i_srst |=> !o_scl_oe && !o_sda_oe && o_host_irq_n &&
      o_locality_sel == `LRP_LOC_RST && o_int_enable == 32'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule
bind lrp_port lrp_checker u_chk (.i_ref_clk, .i_srst, .i_scl, .i_sda, .o_scl_oe, .o_sda_oe,
  .o_sda_o, .o_host_irq_n, .i_irq_flags, .o_wr_stb, .o_hash_start, .o_hash_end,
  .o_locality_sel, .o_int_enable, .o_loc4_active);
`default_nettype wire

// file: bench/lrp_host.sv
// Purpose: behavioural bus master for the register port
// Assumes: open-drain wires with pull-ups, bit of about 40 clocks
// Notes:   retry and guard waits are parameters to keep runs short
`timescale 1ns/1ps
`default_nettype none
`include "lrp_cfg.svh"
module lrp_host #(
  parameter int RETRY_CYC = 500000, // about 2 ms before a retry
  parameter int GUARD_CYC = 62500   // 250 us stop to start
) (
  input  wire logic i_ref_clk, // paces the bus
  input  wire logic i_scl,     // resolved clock wire
  input  wire logic i_sda,     // resolved data wire
  output logic      o_scl_low, // pull clock low
  output logic      o_sda_low  // pull data low
);
  logic guard_done = 1'b0; // lifted once capability was read
  // ----------------------------------------
  // bus primitives; each call finishes before the next
  // ----------------------------------------
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end
  task automatic hq;
    repeat (10) @(posedge i_ref_clk);
  endtask
  // release clock, then wait out a stretch under a bound
  task automatic sh;
    int n;
    o_scl_low <= 1'b0;
    n = 0;
    @(posedge i_ref_clk);
    while (!i_scl && n < 5000) begin
      @(posedge i_ref_clk);
      n++;
    end
    repeat (9) @(posedge i_ref_clk); // keeps one bit at 40 clocks, 160 ns
  endtask
  task automatic bit_io(input logic b, output logic r);
    o_scl_low <= 1'b1;
    hq;
    o_sda_low <= !b;
    hq;
    sh;
    r = i_sda;
    hq;
  endtask
  task automatic start;
    o_scl_low <= 1'b1;
    hq;
    o_sda_low <= 1'b0;
    hq;
    sh;
    o_sda_low <= 1'b1;
    hq;
  endtask
  task automatic stop;
    o_scl_low <= 1'b1;
    hq;
    o_sda_low <= 1'b1;
    hq;
    sh;
    o_sda_low <= 1'b0;
    hq;
    if (!guard_done) repeat (GUARD_CYC) @(posedge i_ref_clk);
  endtask
  task automatic byte_tx(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // write: sub-address first, then bytes low first
  task automatic wr(input logic [6:0] da, input logic [7:0] sub, input int n,
                    input logic [39:0] d, output logic ok);
    start;
    byte_tx({da, 1'b0}, ok);
    if (ok) byte_tx(sub, ok);
    for (int i = 0; i < n && ok; i++) byte_tx(d[8*i +: 8], ok);
    stop;
  endtask
  // read via repeated start, last byte refused by the master
  task automatic rd(input logic [7:0] sub, input int n, output logic [31:0] v,
                    output logic ok);
    logic r;
    v = 32'h0;
    start;
    byte_tx({`LRP_DEV_ADDR_RST, 1'b0}, ok);
    if (ok) byte_tx(sub, ok);
    start;
    if (ok) byte_tx({`LRP_DEV_ADDR_RST, 1'b1}, ok);
    for (int i = 0; i < n && ok; i++) begin
      for (int k = 0; k < 8; k++) bit_io(1'b1, v[8*i + 7 - k]);
      bit_io(i == n - 1, r);
    end
    if (sub == `LRP_A_LINK_CAP) guard_done = 1'b1;
    stop;
  endtask
  task automatic backoff;
    repeat (RETRY_CYC) @(posedge i_ref_clk);
  endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Purpose: self-checking bench for the register port
// Assumes: host model drives the bus, bench plays the core
// Notes:   table rows first, awkward cases by hand after
`timescale 1ns/1ps
`default_nettype none
`include "lrp_cfg.svh"
module tb_top;
  localparam logic [31:0] STS = 32'hA5C3_5A3C; // status the core reports
  localparam logic [6:0]  DEV = `LRP_DEV_ADDR_RST;
  typedef struct {logic w; logic [7:0] a; int n; logic [31:0] v;} lrp_row_t;
  logic        clk, srst, busy, h_scl, h_sda, ok, irq_n, stb, scl_oe, sda_oe;
  logic [31:0] flags, got, en;
  logic [7:0]  loc, wa, wd;
  int          bad_count, checks, stb_n, n0;
  wire         scl = !(scl_oe || h_scl);
  wire         sda = !(sda_oe || h_sda);
  lrp_row_t rows [25] = '{
    '{0, 8'h30, 4, `LRP_LINK_CAP_VAL}, '{0, 8'h00, 1, 32'h0}, '{0, 8'h08, 4, 32'h0},
    '{0, 8'h0C, 1, 32'hFF}, '{0, 8'h14, 4, `LRP_INT_SUP_VAL},
    '{0, 8'h4C, 2, {16'h0, 8'hFF, `LRP_REV_VAL}}, '{0, 8'h18, 4, 32'hFFFF_FFFF},
    '{0, 8'h24, 2, 32'hFFFF}, '{1, 8'h08, 4, 32'hFFFF_FFFF}, '{0, 8'h08, 4, `LRP_INT_EN_MASK},
    '{0, 8'h08, 1, 32'h87}, '{1, 8'h00, 1, 32'h04}, '{1, 8'h28, 1, 32'h0},
    '{0, 8'h28, 1, 32'hFF}, '{0, 8'h18, 4, STS}, '{0, 8'h19, 2, {16'h0, STS[23:8]}},
    '{0, 8'h1B, 1, {24'h0, STS[31:24]}}, '{0, 8'h24, 2, 32'h3C3C}, '{1, 8'h1B, 1, 32'hA5},
    '{1, 8'h19, 2, 32'h0}, '{1, 8'h00, 1, 32'h02}, '{0, 8'h00, 1, 32'h04},
    '{1, 8'h20, 1, 32'h0}, '{0, 8'h18, 1, 32'hFF}, '{0, 8'h20, 1, 32'hFF}};
  lrp_port u_dut (.i_ref_clk(clk), .i_srst(srst), .i_scl(scl), .i_sda(sda),
    .o_scl_oe(scl_oe), .o_sda_oe(sda_oe), .o_sda_o(), .o_host_irq_n(irq_n), .i_busy(busy),
    .i_sts(STS), .i_irq_flags(flags), .i_resp_valid(1'b1), .i_resp_data(8'h3C),
    .o_resp_pop(), .o_wr_stb(stb), .o_wr_addr(wa), .o_wr_data(wd), .o_hash_start(),
    .o_hash_end(), .o_locality_sel(loc), .o_int_enable(en), .o_loc4_active());
  lrp_host #(.RETRY_CYC(200)) u_host (.i_ref_clk(clk), .i_scl(scl), .i_sda(sda),
    .o_scl_low(h_scl), .o_sda_low(h_sda));
  // ----------------------------------------
  // clock, commit counter, checks, verdict
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (stb) stb_n <= stb_n + 1;
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      bad_count++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // watchdog sized well above the expected 60k cycles
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    print_verdict;
  end
  initial begin
    srst = 1'b1;
    busy = 1'b0;
    flags = 32'h0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (6) @(posedge clk);
    foreach (rows[i]) begin
      if (rows[i].w) u_host.wr(DEV, rows[i].a, rows[i].n, {8'h0, rows[i].v}, ok);
      else u_host.rd(rows[i].a, rows[i].n, got, ok);
      chk({31'h0, ok}, 32'h1);
      if (!rows[i].w) chk(got, rows[i].v);
    end
    // interrupt pin follows enabled flags and the global enable
    @(posedge clk) flags <= 32'h1;
    repeat (8) @(posedge clk);
    chk({31'h0, irq_n}, 32'h0);
    u_host.wr(DEV, 8'h08, 4, 40'h87, ok);
    repeat (8) @(posedge clk);
    chk({31'h0, irq_n}, 32'h1);
    // wrong address, then busy core, both refused
    u_host.wr(7'h2F, 8'h00, 1, 40'h01, ok);
    chk({31'h0, ok}, 32'h0);
    u_host.backoff;
    @(posedge clk) busy <= 1'b1;
    u_host.wr(DEV, 8'h00, 1, 40'h01, ok);
    chk({31'h0, ok}, 32'h0);
    @(posedge clk) busy <= 1'b0;
    u_host.backoff;
    // overlong write refused and dropped whole, then repeated
    n0 = stb_n;
    u_host.wr(DEV, 8'h08, 5, 40'h01_8000_0001, ok);
    chk({31'h0, ok}, 32'h0);
    u_host.rd(8'h08, 4, got, ok);
    chk(got, 32'h87);
    chk(32'(stb_n - n0), 32'h0);
    u_host.backoff;
    u_host.wr(DEV, 8'h08, 4, 40'h8000_0001, ok);
    chk(en, 32'h8000_0001);
    chk(32'(stb_n - n0), 32'h1);
    // second reset in mid-run restores locality and enables
    u_host.wr(DEV, 8'h00, 1, 40'h03, ok);
    chk({24'h0, loc}, 32'h3);
    @(posedge clk) srst <= 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (6) @(posedge clk);
    chk({24'h0, loc}, 32'h0);
    chk(en, 32'h0);
    u_host.rd(8'h00, 1, got, ok);
    chk(got, 32'h0);
    // overrun write of two bytes still lands in the start register
    u_host.wr(DEV, 8'h00, 2, 40'h0201, ok);
    chk({24'h0, loc}, 32'h1);
    chk({16'h0, wa, wd}, 32'h0001);
    print_verdict;
  end
endmodule
`default_nettype wire
